// ---- core/status_summary_pkg.sv ----
// Purpose: Constants for the status summary register block.
// Assumes: Single 10 MHz clock, synchronous active-high reset.
// Notes: Bit positions and addresses of the status byte and status word.
// Function
// - The overcurrent fault bit latches when a timed-out overcurrent has shut the gate drive down.
// - Status byte bit 3 latches when an undervoltage is seen on the undervoltage pin.
// - Status byte bit 2 is 1 while any temperature status bit is active.
// - Status byte bit 1 latches on any communication error or trim-memory error.
// - Status byte bit 0 is 1 while any other status group holds an unreported active bit.
// - Status word bit 15 is the live OR of the output-voltage status bits.
// - Status word bit 14 is the live OR of the output-current status bits.
// - Status word bit 13 is the live OR of the input status bits.
// - Status word bit 12 is the live OR of the vendor status bits.
// - Status word bit 11 is 1 while the power-good sense input is below threshold.
// - Status word bit 8 latches when a pass transistor fault is detected.
// - The status word resets to zero, its low byte equals the status byte, and bits 10:9, 7, 5 read 0.
// - Status byte bit 6 is 1 while the gate drive is disabled.
// - The status byte resets to zero, bits 7 and 5 read 0, and bit 4 holds the overcurrent flag.
package status_summary_pkg;
  localparam logic [7:0]  ADDR_STATUS_BYTE  = 8'h78;
  localparam logic [7:0]  ADDR_STATUS_WORD  = 8'h79;
  localparam logic [7:0]  RESET_BYTE        = 8'h00;
  localparam logic [15:0] RESET_WORD        = 16'h0000;
  localparam logic [1:0]  RESET_POWER_GOOD_SYNC = 2'h3;
  localparam int BIT_OTHER     = 0;
  localparam int BIT_COMM      = 1;
  localparam int BIT_TEMP      = 2;
  localparam int BIT_UNDERVOLT = 3;
  localparam int BIT_OVERCURR  = 4;
  localparam int BIT_GATE_OFF  = 6;
  localparam int BIT_PASS_FET  = 8;
  localparam int BIT_PWR_BAD   = 11;
  localparam int BIT_VENDOR    = 12;
  localparam int BIT_INPUT     = 13;
  localparam int BIT_IOUT      = 14;
  localparam int BIT_VOUT      = 15;
endpackage : status_summary_pkg

// ---- core/status_summary_regs.sv ----
// Purpose: Top-level fault and warning summary: status byte and status word.
// Assumes: Event inputs come from logic on sys_clk; pins pass a two-stage synchroniser.
// Notes: Read port returns the snapshot register selected by read_addr.
`timescale 1ns/1ps
`default_nettype none
module status_summary_regs (
  // Clock and reset.
  input  wire  logic        sys_clk,
  input  wire  logic        rst,
  // Fault events from on-chip logic, one-cycle pulses or levels.
  input  wire  logic        overcurrent_shutdown_event,
  input  wire  logic        comm_error_event,
  input  wire  logic        trim_error_event,
  input  wire  logic        pass_transistor_event,
  input  wire  logic        gate_drive_disabled,
  // Pins from outside the clock domain.
  input  wire  logic        undervolt_pin,
  input  wire  logic        power_good_sense_input,
  // Group status registers summarised here.
  input  wire  logic [7:0]  temp_status,
  input  wire  logic [7:0]  output_voltage_group_pending,
  input  wire  logic [7:0]  output_current_group_pending,
  input  wire  logic [7:0]  input_status,
  input  wire  logic [7:0]  vendor_status,
  input  wire  logic        other_group_pending,
  // Fault-clearing command from the host command decoder.
  input  wire  logic        clear_faults,
  // Read port.
  input  wire  logic [7:0]  read_addr,
  output logic [15:0]       read_data,
  output logic              read_hit,
  // Snapshot registers.
  output logic [7:0]        status_summary_byte,
  output logic [15:0]       status_summary_word
);

  logic [1:0]  undervolt_sync_reg;
  logic [1:0]  power_good_sync_reg;
  logic        overcurrent_shutdown_flag;
  logic        input_undervolt_flag;
  logic        comm_or_trim_error;
  logic        pass_transistor_fault;
  logic [15:0] word_next;

  // True when any bit of a group status register is active.
  function automatic logic group_active(input logic [7:0] bits);
    return |bits;
  endfunction

  // Two-stage synchronisers for the pins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      undervolt_sync_reg  <= 2'h0;
      power_good_sync_reg <= status_summary_pkg::RESET_POWER_GOOD_SYNC; // Good level, so no false power-bad.
    end else begin
      undervolt_sync_reg  <= {undervolt_sync_reg[0], undervolt_pin};
      power_good_sync_reg <= {power_good_sync_reg[0], power_good_sense_input};
    end
  end

  // Latched flags; a present cause wins over a clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overcurrent_shutdown_flag <= 1'b0;
      input_undervolt_flag      <= 1'b0;
      comm_or_trim_error        <= 1'b0;
      pass_transistor_fault     <= 1'b0;
    end else begin
      overcurrent_shutdown_flag <= overcurrent_shutdown_event | (overcurrent_shutdown_flag & ~clear_faults);
      input_undervolt_flag      <= undervolt_sync_reg[1] | (input_undervolt_flag & ~clear_faults);
      comm_or_trim_error        <= comm_error_event | trim_error_event | (comm_or_trim_error & ~clear_faults);
      pass_transistor_fault     <= pass_transistor_event | (pass_transistor_fault & ~clear_faults);
    end
  end

  // Next word from latched flags and live summaries.
  always_comb begin
    word_next = status_summary_pkg::RESET_WORD;
    word_next[status_summary_pkg::BIT_OTHER]     = other_group_pending;
    word_next[status_summary_pkg::BIT_COMM]      = comm_or_trim_error;
    word_next[status_summary_pkg::BIT_TEMP]      = group_active(temp_status);
    word_next[status_summary_pkg::BIT_UNDERVOLT] = input_undervolt_flag;
    word_next[status_summary_pkg::BIT_OVERCURR]  = overcurrent_shutdown_flag;
    word_next[status_summary_pkg::BIT_GATE_OFF]  = gate_drive_disabled;
    word_next[status_summary_pkg::BIT_PASS_FET]  = pass_transistor_fault;
    word_next[status_summary_pkg::BIT_PWR_BAD]   = ~power_good_sync_reg[1];
    word_next[status_summary_pkg::BIT_VENDOR]    = group_active(vendor_status);
    word_next[status_summary_pkg::BIT_INPUT]     = group_active(input_status);
    word_next[status_summary_pkg::BIT_IOUT]      = group_active(output_current_group_pending);
    word_next[status_summary_pkg::BIT_VOUT]      = group_active(output_voltage_group_pending);
  end

  // One snapshot edge feeds both registers, so they always agree.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_summary_word <= status_summary_pkg::RESET_WORD;
      status_summary_byte <= status_summary_pkg::RESET_BYTE;
    end else begin
      status_summary_word <= word_next;
      status_summary_byte <= word_next[7:0];
    end
  end

  // Read mux, registered so data stays a flop output.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      read_data <= status_summary_pkg::RESET_WORD;
      read_hit  <= 1'b0;
    end else if (read_addr == status_summary_pkg::ADDR_STATUS_WORD) begin
      read_data <= status_summary_word;
      read_hit  <= 1'b1;
    end else if (read_addr == status_summary_pkg::ADDR_STATUS_BYTE) begin
      read_data <= {8'h00, status_summary_byte};
      read_hit  <= 1'b1;
    end else begin
      read_data <= 16'h0000;
      read_hit  <= 1'b0;
    end
  end

  // Checks.
  sequence fault_seen;
    overcurrent_shutdown_event;
  endsequence
  sequence flag_held;
    status_summary_word[status_summary_pkg::BIT_OVERCURR] [*2];
  endsequence

  a_overcurrent_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
    fault_seen ##1 !clear_faults |=> flag_held)
    else $error("overcurrent flag not latched");
  a_undervolt_latch_set: assert property (@(posedge sys_clk) disable iff (rst)
    undervolt_pin |-> ##4 status_summary_byte[status_summary_pkg::BIT_UNDERVOLT])
    else $error("undervolt flag not set");
  a_temp_summary_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_byte[status_summary_pkg::BIT_TEMP] == (|$past(temp_status)))
    else $error("temperature summary wrong");
  a_comm_error_latch: assert property (@(posedge sys_clk) disable iff (rst)
    (comm_error_event || trim_error_event) |-> ##2 status_summary_byte[status_summary_pkg::BIT_COMM])
    else $error("comm error not latched");
  a_other_group_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_byte[status_summary_pkg::BIT_OTHER] == $past(other_group_pending))
    else $error("other group bit wrong");
  a_vout_summary_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[status_summary_pkg::BIT_VOUT] == (|$past(output_voltage_group_pending)))
    else $error("vout summary wrong");
  a_iout_summary_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[status_summary_pkg::BIT_IOUT] == (|$past(output_current_group_pending)))
    else $error("iout summary wrong");
  a_input_summary_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[status_summary_pkg::BIT_INPUT] == (|$past(input_status)))
    else $error("input summary wrong");
  a_vendor_summary_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[status_summary_pkg::BIT_VENDOR] == (|$past(vendor_status)))
    else $error("vendor summary wrong");
  a_power_bad_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (!power_good_sense_input) [*4] |-> status_summary_word[status_summary_pkg::BIT_PWR_BAD])
    else $error("power bad not reported");
  a_fet_fault_latch: assert property (@(posedge sys_clk) disable iff (rst)
    pass_transistor_event |-> ##2 status_summary_word[status_summary_pkg::BIT_PASS_FET])
    else $error("fet fault not latched");
  a_word_byte_match: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[7:0] == status_summary_byte && status_summary_word[10:9] == 2'h0)
    else $error("word low byte mismatch");
  a_gate_off_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_byte[status_summary_pkg::BIT_GATE_OFF] == $past(gate_drive_disabled))
    else $error("gate off bit wrong");
  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !status_summary_byte[7] && !status_summary_byte[5])
    else $error("reserved bit set");
  a_clear_drops_flag: assert property (@(posedge sys_clk) disable iff (rst)
    clear_faults && !comm_error_event && !trim_error_event |-> ##2
      (!status_summary_byte[status_summary_pkg::BIT_COMM] || $past(comm_error_event || trim_error_event)))
    else $error("clear ignored");
  a_read_snapshot: assert property (@(posedge sys_clk) disable iff (rst)
    $past(read_addr) == status_summary_pkg::ADDR_STATUS_WORD |-> read_data == $past(status_summary_word))
    else $error("read not from snapshot");

  // Steps of a clear: the command arrives while the cause is absent.
  sequence oc_clear_step;
    clear_faults && !overcurrent_shutdown_event;
  endsequence
  sequence uv_clear_step;
    clear_faults && !undervolt_sync_reg[1];
  endsequence
  sequence fet_clear_step;
    clear_faults && !pass_transistor_event;
  endsequence

  // Overcurrent flag reaches the status byte two edges after its event.
  a_oc_byte_bit: assert property (@(posedge sys_clk) disable iff (rst)
    overcurrent_shutdown_event |-> ##2 status_summary_byte[status_summary_pkg::BIT_OVERCURR])
    else $error("overcurrent byte bit not set");

  // A clear with no overcurrent present empties the word bit two edges later.
  a_oc_clear_drop: assert property (@(posedge sys_clk) disable iff (rst)
    oc_clear_step |-> ##2 !status_summary_word[status_summary_pkg::BIT_OVERCURR])
    else $error("overcurrent flag survived clear");

  // A clear while the synced undervolt level is low empties the byte bit.
  a_uv_clear_drop: assert property (@(posedge sys_clk) disable iff (rst)
    uv_clear_step |-> ##2 !status_summary_byte[status_summary_pkg::BIT_UNDERVOLT])
    else $error("undervolt flag survived clear");

  // A clear with no pass transistor event empties the word bit.
  a_fet_clear_drop: assert property (@(posedge sys_clk) disable iff (rst)
    fet_clear_step |-> ##2 !status_summary_word[status_summary_pkg::BIT_PASS_FET])
    else $error("fet flag survived clear");

  // An error in the same cycle as a clear keeps the flag set.
  a_comm_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
    (comm_error_event || trim_error_event) && clear_faults |=> comm_or_trim_error)
    else $error("clear beat a comm error");

  // The overcurrent flag holds while no clear arrives.
  a_oc_flag_stays: assert property (@(posedge sys_clk) disable iff (rst)
    overcurrent_shutdown_flag && !clear_faults |=> overcurrent_shutdown_flag)
    else $error("overcurrent flag dropped");

  // The undervolt flag holds while no clear arrives.
  a_uv_flag_stays: assert property (@(posedge sys_clk) disable iff (rst)
    input_undervolt_flag && !clear_faults |=> input_undervolt_flag)
    else $error("undervolt flag dropped");

  // The comm or trim flag holds while no clear arrives.
  a_comm_flag_stays: assert property (@(posedge sys_clk) disable iff (rst)
    comm_or_trim_error && !clear_faults |=> comm_or_trim_error)
    else $error("comm flag dropped");

  // The pass transistor flag holds while no clear arrives.
  a_fet_flag_stays: assert property (@(posedge sys_clk) disable iff (rst)
    pass_transistor_fault && !clear_faults |=> pass_transistor_fault)
    else $error("fet flag dropped");

  // The overcurrent flag never rises without its event.
  a_oc_needs_cause: assert property (@(posedge sys_clk) disable iff (rst)
    !overcurrent_shutdown_flag && !overcurrent_shutdown_event |=> !overcurrent_shutdown_flag)
    else $error("overcurrent flag rose alone");

  // The undervolt flag never rises without the synced pin.
  a_uv_needs_cause: assert property (@(posedge sys_clk) disable iff (rst)
    !input_undervolt_flag && !undervolt_sync_reg[1] |=> !input_undervolt_flag)
    else $error("undervolt flag rose alone");

  // The comm or trim flag never rises without an error.
  a_comm_needs_cause: assert property (@(posedge sys_clk) disable iff (rst)
    !comm_or_trim_error && !comm_error_event && !trim_error_event |=> !comm_or_trim_error)
    else $error("comm flag rose alone");

  // The pass transistor flag never rises without its event.
  a_fet_needs_cause: assert property (@(posedge sys_clk) disable iff (rst)
    !pass_transistor_fault && !pass_transistor_event |=> !pass_transistor_fault)
    else $error("fet flag rose alone");

  // A trim memory error alone reaches the word bit two edges later.
  a_trim_error_latch: assert property (@(posedge sys_clk) disable iff (rst)
    trim_error_event |-> ##2 status_summary_word[status_summary_pkg::BIT_COMM])
    else $error("trim error not latched");

  // Power good held for four edges clears the power-bad bit.
  a_power_good_clear: assert property (@(posedge sys_clk) disable iff (rst)
    power_good_sense_input [*4] |-> !status_summary_word[status_summary_pkg::BIT_PWR_BAD])
    else $error("power bad stuck");

  // A byte read returns the byte snapshot with a zero upper byte.
  a_read_byte_path: assert property (@(posedge sys_clk) disable iff (rst)
    $past(read_addr) == status_summary_pkg::ADDR_STATUS_BYTE |-> read_data == {8'h00, $past(status_summary_byte)})
    else $error("byte read wrong");

  // The hit flag marks exactly the two mapped addresses.
  a_read_hit_map: assert property (@(posedge sys_clk) disable iff (rst)
    read_hit == ($past(read_addr) == status_summary_pkg::ADDR_STATUS_WORD ||
                 $past(read_addr) == status_summary_pkg::ADDR_STATUS_BYTE))
    else $error("read hit wrong");

  // Unmapped addresses read as zero.
  a_unmapped_read_zero: assert property (@(posedge sys_clk) disable iff (rst)
    $past(read_addr) != status_summary_pkg::ADDR_STATUS_WORD &&
    $past(read_addr) != status_summary_pkg::ADDR_STATUS_BYTE |-> read_data == 16'h0000)
    else $error("unmapped read not zero");

  // Reserved bits 7 and 5 of the word stay zero.
  a_word_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
    !status_summary_word[7] && !status_summary_word[5])
    else $error("word reserved bit set");

  // The word repeats the other-group bit from the previous edge.
  a_other_word_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[status_summary_pkg::BIT_OTHER] == $past(other_group_pending))
    else $error("word other group bit wrong");

  // The word repeats the gate-off bit from the previous edge.
  a_gate_off_word: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[status_summary_pkg::BIT_GATE_OFF] == $past(gate_drive_disabled))
    else $error("word gate off bit wrong");

  // The word repeats the temperature summary from the previous edge.
  a_temp_word_live: assert property (@(posedge sys_clk) disable iff (rst)
    status_summary_word[status_summary_pkg::BIT_TEMP] == (|$past(temp_status)))
    else $error("word temperature bit wrong");

  // A reset edge leaves both snapshots at their reset values.
  a_reset_clears_regs: assert property (@(posedge sys_clk)
    rst |=> status_summary_word == status_summary_pkg::RESET_WORD &&
            status_summary_byte == status_summary_pkg::RESET_BYTE)
    else $error("snapshot not reset");

  // A reset edge leaves the read port idle.
  a_reset_clears_read: assert property (@(posedge sys_clk)
    rst |=> !read_hit && read_data == status_summary_pkg::RESET_WORD)
    else $error("read port not reset");

endmodule : status_summary_regs
`default_nettype wire

// ---- bench/status_host.sv ----
// Purpose: Host-side reader that issues register reads and clear commands.
// Assumes: Requests change at the falling edge of sys_clk.
// Notes: The idle address 0x00 is unmapped, so a released port selects nothing.
`timescale 1ns/1ps
`default_nettype none
module status_host (
  // Clock.
  input  wire logic        sys_clk,
  // Read port of the block.
  input  wire logic [15:0] read_data,
  input  wire logic        read_hit,
  output var  logic [7:0]  read_addr,
  output var  logic        clear_faults
);
  // The port starts released.
  initial begin
    read_addr    = 8'h00;
    clear_faults = 1'b0;
  end
  // Holds an address across one edge, then takes the answer.
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic hit);
    @(negedge sys_clk) read_addr = addr;
    @(negedge sys_clk) data = read_data;
    hit       = read_hit;
    read_addr = 8'h00;
  endtask
  // Issues a one-cycle clear command.
  task automatic clear();
    @(negedge sys_clk) clear_faults = 1'b1;
    @(negedge sys_clk) clear_faults = 1'b0;
  endtask
endmodule // status_host
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the status summary registers.
// Assumes: Inputs change at the falling edge; latencies as handed over.
// Notes: The expected word is rebuilt from bench copies of every source.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0, rst = 1'b1, oc_ev = 1'b0, comm_ev = 1'b0, trim_ev = 1'b0, fet_ev = 1'b0;
  logic        gate_off = 1'b0, uv_pin = 1'b0, pg_pin = 1'b1, other_p = 1'b0, clear_faults, read_hit, h;
  logic        oc_l = 1'b0, uv_l = 1'b0, comm_l = 1'b0, fet_l = 1'b0;
  logic [7:0]  temp_s = 8'h00, vout_s = 8'h00, iout_s = 8'h00, input_s = 8'h00, vendor_s = 8'h00;
  logic [7:0]  read_addr, sbyte;
  logic [15:0] read_data, word, d, e;
  int          error_cnt = 0, compares = 0;
  // Clock of 100 ns.
  always #50 sys_clk = ~sys_clk;
  status_summary_regs status_summary_regs_i (.sys_clk(sys_clk), .rst(rst), .overcurrent_shutdown_event(oc_ev),
    .comm_error_event(comm_ev), .trim_error_event(trim_ev), .pass_transistor_event(fet_ev),
    .gate_drive_disabled(gate_off), .undervolt_pin(uv_pin), .power_good_sense_input(pg_pin), .temp_status(temp_s),
    .output_voltage_group_pending(vout_s), .output_current_group_pending(iout_s), .input_status(input_s), .vendor_status(vendor_s),
    .other_group_pending(other_p), .clear_faults(clear_faults), .read_addr(read_addr), .read_data(read_data),
    .read_hit(read_hit), .status_summary_byte(sbyte), .status_summary_word(word));
  status_host status_host_i (.sys_clk(sys_clk), .read_data(read_data), .read_hit(read_hit),
    .read_addr(read_addr), .clear_faults(clear_faults));
  // Expected word from the bench copies.
  function automatic logic [15:0] exp_w();
    exp_w = {|vout_s, |iout_s, |input_s, |vendor_s, ~pg_pin, 2'b00, fet_l, 1'b0, gate_off, 1'b0, oc_l, uv_l,
             |temp_s, comm_l, other_p};
  endfunction
  // Compares one value and counts it.
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Waits n cycles, then checks both snapshots.
  task automatic look(input int n);
    repeat (n) @(negedge sys_clk);
    e = exp_w();
    chk("word", word, e);
    chk("byte", {8'h00, sbyte}, {8'h00, e[7:0]});
  endtask
  // Clears the latched flags in the design and in the bench copies.
  task automatic do_clear();
    status_host_i.clear();
    {oc_l, uv_l, comm_l, fet_l} = 4'h0;
    look(1);
  endtask
  // Drives each live source other than the power-good pin alone.
  task automatic t_live();
    for (int k = 0; k < 8; k++) begin
      @(negedge sys_clk);
      {temp_s, vout_s, iout_s, input_s, vendor_s, gate_off, other_p} = 42'h0;
      case (k)
        0: temp_s = 8'h80;
        1: vout_s = 8'h40;
        2: iout_s = 8'h20;
        3: input_s = 8'h01;
        4: vendor_s = 8'h10;
        5: other_p = 1'b1;
        6: gate_off = 1'b1;
        default: ;
      endcase
      look(1);
    end
    $display("live test done");
  endtask
  // Pulses each event, checks hold, then clears.
  task automatic t_latch();
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk) {oc_ev, comm_ev, trim_ev, fet_ev} = 4'b1000 >> k;
      @(negedge sys_clk) {oc_ev, comm_ev, trim_ev, fet_ev} = 4'h0;
      {oc_l, comm_l, fet_l} = {k == 0, k == 1 || k == 2, k == 3};
      look(1);
      look(3);
      do_clear();
    end
    @(negedge sys_clk) comm_ev = 1'b1;
    comm_l = 1'b1;
    status_host_i.clear();
    look(1);
    comm_ev = 1'b0;
    do_clear();
    uv_pin = 1'b1;
    uv_l   = 1'b1;
    look(4);
    uv_pin = 1'b0;
    look(3);
    do_clear();
    pg_pin = 1'b0;
    look(3);
    pg_pin = 1'b1;
    look(3);
    $display("latch test done");
  endtask
  // Latches a fault, then checks that a mid-run reset empties both snapshots.
  task automatic t_reset();
    @(negedge sys_clk) oc_ev = 1'b1;
    @(negedge sys_clk) oc_ev = 1'b0;
    oc_l = 1'b1;
    look(1);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst  = 1'b0;
    oc_l = 1'b0;
    look(1);
    $display("reset test done");
  endtask
  // Reads both registers and an unmapped place.
  task automatic t_read();
    temp_s = 8'h02;
    pg_pin = 1'b0;
    look(3);
    status_host_i.read_reg(status_summary_pkg::ADDR_STATUS_BYTE, d, h);
    chk("byte read", d, {8'h00, e[7:0]});
    chk("byte hit", {15'h0000, h}, 16'h0001);
    status_host_i.read_reg(status_summary_pkg::ADDR_STATUS_WORD, d, h);
    chk("word read", d, e);
    chk("word hit", {15'h0000, h}, 16'h0001);
    status_host_i.read_reg(8'h7A, d, h);
    chk("unmapped read", d, 16'h0000);
    chk("unmapped hit", {15'h0000, h}, 16'h0000);
    $display("read test done");
  endtask
  // Prints the counts and the verdict.
  task automatic finish_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    look(1);
    t_live();
    t_latch();
    t_reset();
    t_read();
    finish_test();
  end
  // Watchdog well beyond the expected run.
  initial begin
    #300000;
    error_cnt++;
    finish_test();
  end
endmodule // testbench
`default_nettype wire
